/* File: scf_pkg.sv */
// scf_pkg: constants, state codes and crc step for the stack frame block
// assumes: byte-wide receive and transmit streams, one system clock
package scf_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int REG_NUM    = 16;
  localparam int PAY_MAX    = 8;

  // ----------------------------------------------------------------
  // register offsets and reset value
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_CMD  = 16'h0002;
  localparam logic [3:0]  IDX_CMD   = 4'h2;
  localparam logic [3:0]  IDX_CHSEL = 4'h3;
  localparam logic [3:0]  IDX_AVG   = 4'h7;
  localparam logic [3:0]  IDX_NODE  = 4'ha;
  localparam logic [3:0]  IDX_GROUP = 4'hb;
  localparam logic [7:0]  REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // initialization byte fields
  // ----------------------------------------------------------------
  localparam int KIND_BIT   = 7;
  localparam int REQ_HI     = 6;
  localparam int REQ_LO     = 4;
  localparam int WIDE_BIT   = 3;
  localparam int LEN_HI     = 2;
  localparam logic [2:0] LEN_CODE_MAX  = 3'h7;
  localparam logic [3:0] LEN_MAX_BYTES = 4'h8;
  localparam logic [7:0] SKIP_EXTRA    = 8'h03;

  // request kinds, matched against field bits 2:1; field bit 0 set means no reply
  localparam logic [1:0] REQ_SINGLE = 2'h0;
  localparam logic [1:0] REQ_GROUP  = 2'h1;
  localparam logic [1:0] REQ_RSVD   = 2'h2;
  localparam logic [1:0] REQ_BCAST  = 2'h3;

  // ----------------------------------------------------------------
  // check value
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'ha001;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_TARGET  = 4'b0001,
    ST_ADDR_HI = 4'b0010,
    ST_ADDR_LO = 4'b0011,
    ST_DATA    = 4'b0100,
    ST_CRC_LO  = 4'b0101,
    ST_CRC_HI  = 4'b0110,
    ST_EXEC    = 4'b0111,
    ST_REPLY   = 4'b1000,
    ST_SKIP    = 4'b1001
  } scf_state_t;

  // one byte, least significant bit first, reflected polynomial
  function automatic logic [15:0] scf_crc_byte(input logic [15:0] c,
                                               input logic [7:0]  d);
    logic [15:0] r;
    logic        b;
    r = c;
    b = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = r[0] ^ d[i];
      r = {1'b0, r[15:1]};
      if (b) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction : scf_crc_byte

endpackage : scf_pkg

/* File: scf_framer.sv */
// scf_framer: command frame receiver, register file and reply framer
// assumes: rx bytes arrive already deserialised, synchronous to clk_sys;
// the serial line layer detects the break and pulses comm_clear
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// shift-register fifo, head always in entry zero
// ------------------------------------------------------------------
module scf_fifo
  import scf_pkg::*;
#(
  parameter int W = BYTE_W,
  parameter int D = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset_n,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output var  logic         in_ready,
  // drain side
  output var  logic         out_valid,
  output var  logic [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CW-1:0]       cnt;
    logic                nempty;
    logic                nfull;
  } scf_fifo_t;

  scf_fifo_t s;
  scf_fifo_t next_s;
  logic      push;
  logic      pop;
  logic [CW-1:0] wi;

  always_comb begin
    next_s = s;
    push   = in_valid && s.nfull;
    pop    = out_ready && s.nempty;
    wi     = s.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < D - 1; i++) begin
        next_s.mem[i] = s.mem[i + 1];
      end
    end
    if (push) begin
      next_s.mem[wi] = in_data;
    end
    next_s.cnt    = s.cnt + CW'(push) - CW'(pop);
    next_s.nempty = next_s.cnt != '0;
    next_s.nfull  = next_s.cnt != CW'(D);
  end

  // registered flags keep both ready and valid glitch free
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s       <= '0;
      s.nfull <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign in_ready  = s.nfull;
  assign out_valid = s.nempty;
  assign out_data  = s.mem[0];
endmodule : scf_fifo

// ------------------------------------------------------------------
// framer top
// ------------------------------------------------------------------
module scf_framer
  import scf_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // receive byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output var  logic        rx_ready,
  input  wire logic        comm_clear,
  // transmit byte stream
  output var  logic        tx_valid,
  output var  logic [7:0]  tx_data,
  input  wire logic        tx_ready,
  // command and configuration
  output var  logic        cmd_strobe,
  output var  logic [7:0]  command_trigger,
  output var  logic [7:0]  cmd_top_addr,
  output var  logic [31:0] channel_select,
  output var  logic [7:0]  sample_averaging,
  output var  logic [7:0]  node_address,
  output var  logic [7:0]  group_identifier,
  output var  logic        crc_error
);
  typedef struct packed {
    scf_state_t                    st;
    logic [REG_NUM-1:0][7:0]       regs;
    logic [PAY_MAX-1:0][7:0]       pay;
    logic [2:0]                    kind;
    logic                          wide;
    logic [3:0]                    plen;
    logic [3:0]                    idx;
    logic [7:0]                    target;
    logic [15:0]                   addr;
    logic [15:0]                   crc;
    logic [15:0]                   tcrc;
    logic [4:0]                    rlen;
    logic [4:0]                    ridx;
    logic [7:0]                    skip;
    logic                          rx_ready;
    logic                          cmd_strobe;
    logic [7:0]                    cmd_top;
    logic                          crc_error;
  } scf_top_t;

  scf_top_t    s;
  scf_top_t    next_s;
  logic        acc;
  logic        push;
  logic [7:0]  push_data;
  logic        fifo_ready;
  logic        match;
  logic [15:0] fin;
  logic [15:0] wa;
  logic [15:0] ra;
  logic [4:0]  want;

  // ----------------------------------------------------------------
  // frame parser and executor
  // ----------------------------------------------------------------
  always_comb begin
    next_s            = s;
    next_s.cmd_strobe = 1'b0;
    next_s.crc_error  = 1'b0;
    acc       = rx_valid && s.rx_ready;
    push      = 1'b0;
    push_data = 8'h00;
    match     = 1'b0;
    fin       = scf_crc_byte(s.crc, rx_data);
    wa        = 16'h0000;
    ra        = s.addr + {11'h000, s.ridx} - 16'h0001;
    want      = 5'h00;
    if (comm_clear) begin
      next_s.st = ST_IDLE;
    end else begin
      unique case (s.st)
        ST_IDLE: if (acc) begin
          next_s.crc    = scf_crc_byte(CRC_INIT, rx_data);
          next_s.kind   = rx_data[REQ_HI:REQ_LO];
          next_s.wide   = rx_data[WIDE_BIT];
          next_s.addr   = 16'h0000;
          next_s.target = 8'h00;
          next_s.idx    = 4'h0;
          next_s.plen   = (rx_data[LEN_HI:0] == LEN_CODE_MAX) ?
                          LEN_MAX_BYTES : {1'b0, rx_data[LEN_HI:0]};
          if (!rx_data[KIND_BIT]) begin
            // a reply from below: pass over it by its own length
            next_s.skip = {1'b0, rx_data[6:0]} + SKIP_EXTRA;
            next_s.st   = ST_SKIP;
          end else if (rx_data[REQ_HI:REQ_HI-1] == REQ_BCAST) begin
            next_s.st = rx_data[WIDE_BIT] ? ST_ADDR_HI : ST_ADDR_LO;
          end else begin
            next_s.st = ST_TARGET;
          end
        end
        ST_SKIP: if (acc) begin
          next_s.skip = s.skip - 8'h01;
          if (s.skip == 8'h01) begin
            next_s.st = ST_IDLE;
          end
        end
        ST_TARGET: if (acc) begin
          next_s.crc    = fin;
          next_s.target = rx_data;
          next_s.st     = s.wide ? ST_ADDR_HI : ST_ADDR_LO;
        end
        ST_ADDR_HI: if (acc) begin
          next_s.crc        = fin;
          next_s.addr[15:8] = rx_data;
          next_s.st         = ST_ADDR_LO;
        end
        ST_ADDR_LO: if (acc) begin
          next_s.crc       = fin;
          next_s.addr[7:0] = rx_data;
          next_s.st        = (s.plen == 4'h0) ? ST_CRC_LO : ST_DATA;
        end
        ST_DATA: if (acc) begin
          next_s.crc          = fin;
          next_s.pay[s.idx[2:0]] = rx_data;
          next_s.idx          = s.idx + 4'h1;
          if (s.idx == s.plen - 4'h1) begin
            next_s.st = ST_CRC_LO;
          end
        end
        ST_CRC_LO: if (acc) begin
          next_s.crc = fin;
          next_s.st  = ST_CRC_HI;
        end
        ST_CRC_HI: if (acc) begin
          // zero remainder over frame and trailer means a good frame
          if (fin != 16'h0000) begin
            next_s.crc_error = 1'b1;
            next_s.st        = ST_IDLE;
          end else begin
            next_s.st = ST_EXEC;
          end
        end
        ST_EXEC: begin
          next_s.st = ST_IDLE;
          unique case (s.kind[2:1])
            REQ_SINGLE: match = s.target == s.regs[IDX_NODE];
            REQ_GROUP:  match = s.target == s.regs[IDX_GROUP];
            REQ_BCAST:  match = 1'b1;
            REQ_RSVD:   match = 1'b0;
          endcase
          if (match && s.addr == ADDR_CMD) begin
            if (s.plen != 4'h0) begin
              next_s.regs[IDX_CMD] = s.pay[0];
              next_s.cmd_top       = (s.plen > 4'h1) ? s.pay[1] : 8'h00;
              next_s.cmd_strobe    = 1'b1;
              for (int i = 2; i < 7; i++) begin
                if (4'(i) < s.plen) begin
                  next_s.regs[i + 1] = s.pay[i];
                end
              end
            end
          end else if (match && s.kind[0]) begin
            for (int i = 0; i < PAY_MAX; i++) begin
              wa = s.addr + 16'(i);
              if (4'(i) < s.plen && wa < 16'(REG_NUM)) begin
                next_s.regs[wa[3:0]] = s.pay[i];
              end
            end
          end else if (match) begin
            // reply length from first payload byte, capped at the file
            want = (s.plen == 4'h0) ? 5'h01 :
                   (s.pay[0] >= 8'(REG_NUM)) ? 5'(REG_NUM) :
                   5'(s.pay[0]) + 5'h01;
            next_s.rlen = want;
            next_s.ridx = 5'h00;
            next_s.tcrc = CRC_INIT;
            next_s.st   = ST_REPLY;
          end
        end
        ST_REPLY: if (fifo_ready) begin
          push = 1'b1;
          if (s.ridx == 5'h00) begin
            push_data = {1'b0, 2'b00, s.rlen - 5'h01};
          end else if (s.ridx <= s.rlen) begin
            push_data = (ra < 16'(REG_NUM)) ? s.regs[ra[3:0]] : 8'h00;
          end else if (s.ridx == s.rlen + 5'h01) begin
            push_data = s.tcrc[7:0];
          end else begin
            push_data = s.tcrc[15:8];
            next_s.st = ST_IDLE;
          end
          if (s.ridx <= s.rlen) begin
            next_s.tcrc = scf_crc_byte(s.tcrc, push_data);
          end
          next_s.ridx = s.ridx + 5'h01;
        end
        default: next_s.st = ST_IDLE;
      endcase
    end
    // no bytes taken while acting on a frame or sending a reply
    next_s.rx_ready = next_s.st != ST_EXEC && next_s.st != ST_REPLY;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s    <= '0;
      s.st <= ST_IDLE;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // transmit buffer; a stalled drain holds the reply state
  // ----------------------------------------------------------------
  scf_fifo #(
    .W (BYTE_W),
    .D (FIFO_DEPTH)
  ) u_txq (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_valid  (push),
    .in_data   (push_data),
    .in_ready  (fifo_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  assign rx_ready         = s.rx_ready;
  assign cmd_strobe       = s.cmd_strobe;
  assign command_trigger  = s.regs[IDX_CMD];
  assign cmd_top_addr     = s.cmd_top;
  assign channel_select   = {s.regs[IDX_CHSEL], s.regs[IDX_CHSEL + 4'h1],
                             s.regs[IDX_CHSEL + 4'h2],
                             s.regs[IDX_CHSEL + 4'h3]};
  assign sample_averaging = s.regs[IDX_AVG];
  assign node_address     = s.regs[IDX_NODE];
  assign group_identifier = s.regs[IDX_GROUP];
  assign crc_error        = s.crc_error;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_no_unsolicited;
    ce && s.st != ST_EXEC && s.st != ST_REPLY |=> s.st != ST_REPLY;
  endproperty
  a_no_unsolicited: assert property (p_no_unsolicited)
    else $error("byte pushed outside reply");

  property p_cmd_target;
    ce && !comm_clear && acc && s.st == ST_IDLE && rx_data[7] &&
      rx_data[6:5] != REQ_BCAST |=> s.st == ST_TARGET;
  endproperty
  a_cmd_target: assert property (p_cmd_target)
    else $error("command init did not go to target byte");

  property p_bcast_skip;
    ce && !comm_clear && acc && s.st == ST_IDLE && rx_data[7] &&
      rx_data[6:5] == REQ_BCAST |=> s.st == ST_ADDR_HI || s.st == ST_ADDR_LO;
  endproperty
  a_bcast_skip: assert property (p_bcast_skip)
    else $error("broadcast expected a target byte");

  property p_narrow_addr;
    ce && !comm_clear && acc && s.st == ST_TARGET && !s.wide
      |=> s.st == ST_ADDR_LO && s.addr[15:8] == 8'h00;
  endproperty
  a_narrow_addr: assert property (p_narrow_addr)
    else $error("short address form has nonzero upper byte");

  property p_len_eight;
    ce && !comm_clear && acc && s.st == ST_IDLE && rx_data[7] &&
      rx_data[2:0] == 3'h7 |=> s.plen == 4'h8;
  endproperty
  a_len_eight: assert property (p_len_eight)
    else $error("length code seven not eight bytes");

  property p_reply_init;
    push && s.ridx == 5'h00 |-> push_data == {3'b000, s.rlen - 5'h01};
  endproperty
  a_reply_init: assert property (p_reply_init)
    else $error("reply init byte length wrong");

  property p_bad_crc;
    ce && !comm_clear && acc && s.st == ST_CRC_HI && fin != 16'h0000
      |=> s.st == ST_IDLE && crc_error && !cmd_strobe;
  endproperty
  a_bad_crc: assert property (p_bad_crc)
    else $error("frame acted on after check failure");

  property p_cmd_write;
    ce && !comm_clear && s.st == ST_EXEC && s.kind[2:1] == REQ_BCAST &&
      s.addr == ADDR_CMD && s.plen != 4'h0
      ##1 ce [*1] |-> cmd_strobe && command_trigger == $past(s.pay[0], 1);
  endproperty
  a_cmd_write: assert property (p_cmd_write)
    else $error("command write not applied");

  property p_clear_sync;
    ce && comm_clear |=> s.st == ST_IDLE;
  endproperty
  a_clear_sync: assert property (p_clear_sync)
    else $error("break did not clear frame sync");

  property p_reply_end;
    ce && !comm_clear && push && s.ridx == s.rlen + 5'h02 |=> s.st == ST_IDLE;
  endproperty
  a_reply_end: assert property (p_reply_end)
    else $error("reply did not end after check bytes");

  c_cmd:   cover property (cmd_strobe);
  c_reply: cover property (push && s.ridx == 5'h00);
  c_crc:   cover property (crc_error);
  c_full:  cover property (s.st == ST_REPLY && !fifo_ready);
endmodule : scf_framer

`default_nettype wire

/* File: scf_host_model.sv */
// scf_host_model: host side of the stack link, sends command frames
// assumes: called 1 ns after a rising clk_sys edge; reply sink stalls
`timescale 1ns/1ps
`default_nettype none
module scf_host_model (
  // clock
  input  wire logic       clk_sys,
  // command byte stream
  output var  logic       rx_valid,
  output var  logic [7:0] rx_data,
  input  wire logic       rx_ready,
  // reply byte stream
  output var  logic       tx_ready,
  input  wire logic       stall,
  // status
  output var  logic       hang
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
    hang     = 1'b0;
  end

  // ----------------------------------------------------------------
  // reply sink, random back-pressure so the fifo really stalls
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    tx_ready <= #1 (!stall && ($urandom_range(3) != 0));
  end

  // ----------------------------------------------------------------
  // check value, bitwise like a plain serial shifter
  // ----------------------------------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'h0000;
    foreach (q[i]) begin
      for (int k = 0; k < 8; k++) begin
        if (c[0] ^ q[i][k]) begin
          c = {1'b0, c[15:1]} ^ 16'ha001;
        end else begin
          c = {1'b0, c[15:1]};
        end
      end
    end
    return c;
  endfunction : crc16

  // ----------------------------------------------------------------
  // byte and frame senders
  // ----------------------------------------------------------------
  task automatic send_byte(input logic [7:0] b);
    logic seen;
    int   n;
    seen     = 1'b0;
    n        = 0;
    rx_valid = 1'b1;
    rx_data  = b;
    // rx_ready only moves on edges, so the value now is the one sampled
    while (!seen && n < 200) begin
      seen = rx_ready;
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (!seen) begin
      hang = 1'b1;
    end
  endtask : send_byte

  task automatic send_frame(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q);
    foreach (q[i]) begin
      send_byte(q[i]);
    end
    send_byte(c[7:0] ^ {7'h00, bad});
    send_byte(c[15:8]);
  endtask : send_frame

  // released line shows the inverse so a stale byte cannot pass
  task automatic release_bus;
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask : release_bus
endmodule : scf_host_model
`default_nettype wire

/* File: stack_command_response_framer_tb.sv */
// stack_command_response_framer_tb: self-checking bench for scf_framer
// assumes: scf_pkg, scf_framer and scf_host_model compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module stack_command_response_framer_tb;
  import scf_pkg::*;
  logic        clk_sys, reset_n, ce, comm_clear, stall, hang;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, cmd_strobe;
  logic        crc_error;
  logic [7:0]  rx_data, tx_data, command_trigger, cmd_top_addr;
  logic [7:0]  sample_averaging, node_address, group_identifier, e, v;
  logic [31:0] channel_select;
  logic [7:0]  regs [16];
  logic [7:0]  exp_q [$];
  int          n_fail, n_tests, n_crc, n_strobe;

  scf_framer uut (.clk_sys(clk_sys), .reset_n(reset_n), .ce(ce),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .comm_clear(comm_clear), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .cmd_strobe(cmd_strobe),
    .command_trigger(command_trigger), .cmd_top_addr(cmd_top_addr),
    .channel_select(channel_select), .sample_averaging(sample_averaging),
    .node_address(node_address), .group_identifier(group_identifier),
    .crc_error(crc_error));
  scf_host_model u_host (.clk_sys(clk_sys), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_ready(tx_ready),
    .stall(stall), .hang(hang));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // output watcher: every reply byte must have been noted beforehand
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset_n && crc_error === 1'b1) n_crc++;
    if (reset_n && cmd_strobe === 1'b1) n_strobe++;
    if (reset_n && ce === 1'b1 && tx_valid === 1'b1 &&
        tx_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(tx_valid, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK(tx_data, e)
      end
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic wait_done;
    int n;
    n = 0;
    repeat (4) @(posedge clk_sys);
    while ((exp_q.size() != 0 || tx_valid !== 1'b0) && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    if (n >= 3000 || hang === 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask : wait_done

  task automatic frame(input logic [7:0] q[$], input logic bad);
    u_host.send_frame(q, bad);
    u_host.release_bus();
    wait_done();
  endtask : frame

  task automatic expect_read(input int a, input int n);
    logic [7:0]  r [$];
    logic [15:0] c;
    r.push_back(8'(n - 1));
    for (int i = 0; i < n; i++) begin
      r.push_back((a + i < 16) ? regs[a + i] : 8'h00);
    end
    c = u_host.crc16(r);
    r.push_back(c[7:0]);
    r.push_back(c[15:8]);
    exp_q = {exp_q, r};
  endtask : expect_read

  task automatic chk_regs(input string name);
    `CHK(node_address, regs[10])
    `CHK(group_identifier, regs[11])
    `CHK(sample_averaging, regs[7])
    `CHK(command_trigger, regs[2])
    `CHK(channel_select, {regs[3], regs[4], regs[5], regs[6]})
    $display("test %s done", name);
  endtask : chk_regs

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n    = 1'b0;
    ce         = 1'b1;
    comm_clear = 1'b0;
    stall      = 1'b0;
    foreach (regs[i]) regs[i] = 8'h00;
    v = 8'($urandom(99252));
    repeat (8) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    @(posedge clk_sys);
    #1;
    `CHK(rx_ready, 1'b1)
    `CHK(tx_valid, 1'b0)
    chk_regs("reset");
    `CHK(u_host.crc16({8'h91, 8'h03, 8'h07, 8'h05}), 16'hcf1e)
    // back to back broadcast writes, no target byte
    u_host.send_frame({8'hf2, 8'h0a, 8'h05, 8'h21}, 1'b0);
    u_host.send_frame({8'hf1, 8'h07, 8'h3c}, 1'b0);
    u_host.release_bus();
    wait_done();
    regs[10] = 8'h05;
    regs[11] = 8'h21;
    regs[7]  = 8'h3c;
    chk_regs("broadcast write");
    // reads of every with-reply kind
    expect_read(10, 2);
    frame({8'h81, 8'h05, 8'h0a, 8'h01}, 1'b0);
    expect_read(10, 1);
    frame({8'ha1, 8'h21, 8'h0a, 8'h00}, 1'b0);
    expect_read(11, 1);
    frame({8'he1, 8'h0b, 8'h00}, 1'b0);
    $display("test reads done");
    // random values through the two-byte address form, read back
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      frame({8'hf9, 8'h00, 8'h07, v}, 1'b0);
      regs[7] = v;
      expect_read(7, 1);
      frame({8'h81, 8'h05, 8'h07, 8'h00}, 1'b0);
    end
    chk_regs("wide address");
    // matching group write acts, frames that must be dropped do not
    frame({8'hb1, 8'h21, 8'h07, 8'h4c}, 1'b0);
    regs[7] = 8'h4c;
    frame({8'h91, 8'h07, 8'h07, 8'h33}, 1'b0);
    frame({8'hb1, 8'h05, 8'h07, 8'h33}, 1'b0);
    frame({8'hc1, 8'h05, 8'h07, 8'h33}, 1'b0);
    frame({8'hd1, 8'h05, 8'h07, 8'h33}, 1'b0);
    frame({8'h01, 8'h33, 8'h44}, 1'b0);
    frame({8'hf9, 8'h01, 8'h07, 8'h33}, 1'b0);
    frame({8'h80, 8'h07, 8'h0a}, 1'b0);
    frame({8'hf1, 8'h07, 8'h33}, 1'b1);
    `CHK(n_crc, 1)
    chk_regs("dropped frames");
    // command register with the eight-byte length code
    frame({8'hf7, 8'h02, 8'h0c, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44,
           8'h66, 8'h77}, 1'b0);
    regs[2] = 8'h0c;
    regs[3] = 8'h11;
    regs[4] = 8'h22;
    regs[5] = 8'h33;
    regs[6] = 8'h44;
    regs[7] = 8'h66;
    `CHK(cmd_top_addr, 8'h03)
    `CHK(n_strobe, 1)
    chk_regs("command register");
    // break in mid-frame, then a clean frame must parse
    u_host.send_byte(8'h91);
    u_host.send_byte(8'h05);
    u_host.release_bus();
    comm_clear = 1'b1;
    @(posedge clk_sys);
    #1 comm_clear = 1'b0;
    frame({8'h91, 8'h05, 8'h0b, 8'h5e}, 1'b0);
    regs[11] = 8'h5e;
    chk_regs("break");
    // long reply against a stalled sink fills the fifo
    stall = 1'b1;
    expect_read(0, 16);
    u_host.send_frame({8'h81, 8'h05, 8'h00, 8'h0f}, 1'b0);
    u_host.release_bus();
    repeat (60) @(posedge clk_sys);
    #1;
    `CHK(tx_valid, 1'b1)
    `CHK(rx_ready, 1'b0)
    // clock enable low: the queue must not drain while the sink takes
    ce    = 1'b0;
    stall = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(exp_q.size(), 19)
    `CHK(tx_valid, 1'b1)
    ce = 1'b1;
    wait_done();
    `CHK(exp_q.size(), 0)
    $display("test fifo full done");
    stop_test();
  end
endmodule : stack_command_response_framer_tb
`default_nettype wire
